/* rtl/axis_io_map.vh */
// Register offsets, field positions, reset values and codes of the axis I/O block.
`ifndef AXIS_IO_MAP_VH
`define AXIS_IO_MAP_VH
`define OFS_CTRL 12'h000
`define OFS_CMD 12'h004
`define OFS_SUBSTAT 12'h008
`define OFS_IRQ_STAT 12'h00c
`define OFS_IRQ_MASK 12'h010
`define OFS_ENC_COUNT 12'h014
`define OFS_HALF_PERIOD 12'h018
`define CTRL_RESET 32'h0000_0000
`define CTRL_SD_LATCH 0
`define CTRL_SD_POL 1
`define CTRL_HOME_POL 2
`define CTRL_ALM_POL 3
`define CTRL_ALM_DECEL 4
`define CTRL_OUT_MODE_LO 5
`define CTRL_OUT_MODE_HI 6
`define CTRL_PULSE_INV 7
`define CTRL_SIGN_INV 8
`define CTRL_ENC_MODE_LO 9
`define CTRL_ENC_MODE_HI 10
`define CTRL_ENC_REV 11
`define CTRL_HOME_USE_INDEX 12
`define CMD_START_PLUS 0
`define CMD_START_MINUS 1
`define CMD_STOP 2
`define CMD_HOME 3
`define CMD_SD_CLEAR 4
`define CMD_ENC_CLEAR 5
`define OUT_COMMON 2'h0
`define OUT_TWO_PULSE 2'h1
`define OUT_QUAD 2'h2
`define ENC_X1 2'h0
`define ENC_X2 2'h1
`define ENC_X4 2'h2
`define ENC_UPDOWN 2'h3
`define IRQ_SD 0
`define IRQ_HOME 1
`define IRQ_ALM 2
`define IRQ_INDEX 3
`define IRQ_STOPPED 4
`define IRQ_BITS 5
`define HALF_PERIOD_RESET 16'h0064
`endif

/* rtl/quad_decoder.v */
// Encoder feedback decoder: quadrature at 1x, 2x, 4x, or separate up/down pulses.
`include "axis_io_map.vh"
module quad_decoder (
  input wire clk_sys,
  input wire rstn,
  input wire phase_a,
  input wire phase_b,
  input wire [1:0] mode,
  input wire reverse,
  output reg step,
  output reg up
);
  reg a_q;
  reg b_q;
  reg fwd;
  reg hit;
  wire a_rise = phase_a & ~a_q;
  wire a_fall = ~phase_a & a_q;
  wire b_rise = phase_b & ~b_q;
  wire b_fall = ~phase_b & b_q;
  wire a_edge = a_rise | a_fall;
  wire b_edge = b_rise | b_fall;

  always @* begin
    fwd = 1'b0;
    hit = 1'b0;
    case (mode)
      `ENC_X1: begin
        // Phase A leading B means B is low when A rises.
        hit = a_rise;
        fwd = ~phase_b;
      end
      `ENC_X2: begin
        hit = a_edge;
        fwd = phase_a ^ phase_b;
      end
      `ENC_X4: begin
        hit = a_edge ^ b_edge;
        fwd = a_edge ? (phase_a ^ phase_b) : ~(phase_a ^ phase_b);
      end
      default: begin
        hit = a_rise ^ b_rise;
        fwd = a_rise;
      end
    endcase
  end

  always @(posedge clk_sys) begin
    if (!rstn) begin
      a_q <= 1'b0;
      b_q <= 1'b0;
      step <= 1'b0;
      up <= 1'b0;
    end else begin
      a_q <= phase_a;
      b_q <= phase_b;
      step <= hit;
      up <= fwd ^ reverse;
    end
  end
endmodule // quad_decoder

/* rtl/axis_pulse_and_sensor_io.v */
// Per-axis motion I/O: sensor conditioning, command pulse output, encoder input.
//
// What this block does
// - Slowdown input stops axis, level or latched.
// - Software selects polarity of slowdown, home, alarm.
// - Sub-status read shows slowdown, home, alarm pins.
// - Home sensor acts on edges during homing.
// - Alarm halts axis instantly or by deceleration.
// - Common mode: pulses on pulse, direction on sign.
// - Two-pulse mode: plus on pulse, minus on sign.
// - Quadrature mode: quarter-period offset encodes direction.
// - Software inverts pulse and sign outputs.
// - Encoder decoded 1x/2x/4x or up/down pulses.
// - Quadrature counts forward when A leads B.
// - Software reverses encoder counting direction.
// - Index marker refines home position during homing.
//
// The register addresses and the APB slave port were decided locally.
`include "axis_io_map.vh"
module axis_pulse_and_sensor_io #(
  parameter DECEL_STEPS = 16,
  parameter COUNT_W = 32
) (
  input wire clk_sys,
  input wire rstn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire minus_slowdown_input_n,
  input wire home_sensor_input_n,
  input wire alarm_input_n,
  input wire encoder_phase_a,
  input wire encoder_phase_b,
  input wire encoder_index_marker_n,
  output reg pulse_out,
  output reg sign_out,
  output reg irq
);
  // ---------------------------------------------------------------
  // State codes
  // ---------------------------------------------------------------
  localparam ST_IDLE = 2'h0;
  localparam ST_RUN = 2'h1;
  localparam ST_DECEL = 2'h2;
  localparam ST_HOME_IDX = 2'h3;

  // ---------------------------------------------------------------
  // Registers and state
  // ---------------------------------------------------------------
  reg [31:0] ctrl;
  reg [15:0] half_period;
  reg [`IRQ_BITS-1:0] irq_stat;
  reg [`IRQ_BITS-1:0] irq_mask;
  reg [COUNT_W-1:0] enc_count;
  reg [1:0] state;
  reg dir_minus;
  reg homing;
  reg sd_latched;
  reg home_q;
  reg alm_q;
  reg [15:0] tick_cnt;
  reg [15:0] decel_cnt;
  reg [1:0] phase;
  reg raw_pulse;
  reg raw_sign;
  reg [`IRQ_BITS-1:0] ev;
  reg [31:0] rd;
  reg [2:0] pol_q;

  // ---------------------------------------------------------------
  // Sensor conditioning
  // ---------------------------------------------------------------
  // Pins are active low by default; for slowdown, home and alarm a polarity bit turns that around.
  wire sd_on = ~minus_slowdown_input_n ^ ctrl[`CTRL_SD_POL];
  wire home_on = ~home_sensor_input_n ^ ctrl[`CTRL_HOME_POL];
  wire alm_on = ~alarm_input_n ^ ctrl[`CTRL_ALM_POL];
  wire index_on = ~encoder_index_marker_n;
  // A write that flips a polarity bit must not pass for a sensor edge.
  wire pol_chg = (ctrl[`CTRL_ALM_POL:`CTRL_SD_POL] != pol_q);
  wire home_edge = home_on & ~home_q & ~pol_chg;
  wire alm_edge = alm_on & ~alm_q & ~pol_chg;
  reg idx_q;
  wire index_edge = index_on & ~idx_q;
  // Slowdown only matters while feeding toward minus.
  wire sd_req = (ctrl[`CTRL_SD_LATCH] ? sd_latched : sd_on) & dir_minus;
  wire moving = (state != ST_IDLE);

  wire [1:0] out_mode = ctrl[`CTRL_OUT_MODE_HI:`CTRL_OUT_MODE_LO];
  wire tick = moving && (tick_cnt == 16'h0000);

  // ---------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------
  wire acc = psel & penable;
  wire wr = acc & pwrite;
  // A write lands at the edge where pready is seen high.
  wire wr_done = wr & pready;
  wire wr_ctrl = wr_done && (paddr == `OFS_CTRL);
  wire wr_stat = wr_done && (paddr == `OFS_IRQ_STAT);
  wire wr_mask = wr_done && (paddr == `OFS_IRQ_MASK);
  wire wr_half = wr_done && (paddr == `OFS_HALF_PERIOD);
  wire known = (paddr == `OFS_CTRL) || (paddr == `OFS_CMD) ||
               (paddr == `OFS_SUBSTAT) || (paddr == `OFS_IRQ_STAT) ||
               (paddr == `OFS_IRQ_MASK) || (paddr == `OFS_ENC_COUNT) ||
               (paddr == `OFS_HALF_PERIOD);

  // ---------------------------------------------------------------
  // Command strobes
  // ---------------------------------------------------------------
  // Commands are one-cycle strobes; the register itself reads as zero.
  wire cmd_wr = wr_done && (paddr == `OFS_CMD);
  wire c_plus = cmd_wr & pwdata[`CMD_START_PLUS];
  wire c_minus = cmd_wr & pwdata[`CMD_START_MINUS];
  wire c_stop = cmd_wr & pwdata[`CMD_STOP];
  wire c_home = cmd_wr & pwdata[`CMD_HOME];
  wire c_sdclr = cmd_wr & pwdata[`CMD_SD_CLEAR];
  wire c_encclr = cmd_wr & pwdata[`CMD_ENC_CLEAR];

  always @* begin
    rd = 32'h0000_0000;
    case (paddr)
      `OFS_CTRL: rd = ctrl;
      // Sub-status: raw pins, conditioned levels, latch and motion state.
      `OFS_SUBSTAT: rd = {22'h00_0000, state, homing, sd_latched, alm_on, home_on, sd_on,
                          alarm_input_n, home_sensor_input_n, minus_slowdown_input_n};
      `OFS_IRQ_STAT: rd[`IRQ_BITS-1:0] = irq_stat;
      `OFS_IRQ_MASK: rd[`IRQ_BITS-1:0] = irq_mask;
      `OFS_ENC_COUNT: rd = enc_count;
      `OFS_HALF_PERIOD: rd[15:0] = half_period;
      default: rd = 32'h0000_0000;
    endcase
  end

  always @(posedge clk_sys) begin
    if (!rstn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      ctrl <= `CTRL_RESET;
      half_period <= `HALF_PERIOD_RESET;
      irq_mask <= {`IRQ_BITS{1'b0}};
    end else begin
      // One wait state: pready rises in the second access cycle.
      pready <= acc & ~pready;
      pslverr <= acc & ~pready & ~known;
      if (acc & ~pready & ~pwrite) begin
        prdata <= rd;
      end
      if (wr_ctrl) begin
        ctrl <= pwdata;
      end
      if (wr_mask) begin
        irq_mask <= pwdata[`IRQ_BITS-1:0];
      end
      if (wr_half) begin
        // Zero would wrap the divider to its longest period, so it is raised to one.
        half_period <= (pwdata[15:0] == 16'h0000) ? 16'h0001 : pwdata[15:0];
      end
    end
  end

  // Polarity history for the edge guard above.
  always @(posedge clk_sys) begin
    if (!rstn) begin
      pol_q <= 3'h0;
    end else begin
      pol_q <= ctrl[`CTRL_ALM_POL:`CTRL_SD_POL];
    end
  end

  // ---------------------------------------------------------------
  // Motion sequencer
  // ---------------------------------------------------------------
  // Deceleration is modelled as a fixed number of further steps at rate,
  // not a true ramp; the profile generator lives outside this block.
  always @(posedge clk_sys) begin
    if (!rstn) begin
      state <= ST_IDLE;
      dir_minus <= 1'b0;
      homing <= 1'b0;
      sd_latched <= 1'b0;
      home_q <= 1'b0;
      alm_q <= 1'b0;
      idx_q <= 1'b0;
      decel_cnt <= 16'h0000;
      tick_cnt <= 16'h0000;
    end else begin
      home_q <= home_on;
      alm_q <= alm_on;
      idx_q <= index_on;
      // Set wins over clear.
      if (sd_on & dir_minus & moving) begin
        sd_latched <= 1'b1;
      end else if (c_sdclr) begin
        sd_latched <= 1'b0;
      end
      // The divider rests at zero, so the first tick falls on the first moving cycle.
      if (moving) begin
        tick_cnt <= (tick_cnt == 16'h0000) ? half_period - 16'h0001 : tick_cnt - 16'h0001;
      end else begin
        tick_cnt <= 16'h0000;
      end
      if (tick && state == ST_DECEL) begin
        decel_cnt <= decel_cnt - 16'h0001;
      end
      case (state)
        ST_IDLE: begin
          homing <= 1'b0;
          if ((c_plus | c_minus | c_home) & ~alm_on) begin
            dir_minus <= c_minus | c_home;
            homing <= c_home;
            state <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (alm_on & ~ctrl[`CTRL_ALM_DECEL]) begin
            state <= ST_IDLE;
          end else if (alm_on | c_stop | sd_req) begin
            decel_cnt <= DECEL_STEPS[15:0];
            state <= ST_DECEL;
          end else if (homing & home_edge) begin
            state <= ctrl[`CTRL_HOME_USE_INDEX] ? ST_HOME_IDX : ST_IDLE;
          end
        end
        ST_DECEL: begin
          if (alm_on & ~ctrl[`CTRL_ALM_DECEL]) begin
            state <= ST_IDLE;
          end else if (decel_cnt == 16'h0000) begin
            state <= ST_IDLE;
          end
        end
        ST_HOME_IDX: begin
          // Creep on until the encoder's once-per-turn marker.
          // Alarm and stop follow the same rules as in the run state.
          if (alm_on & ~ctrl[`CTRL_ALM_DECEL]) begin
            state <= ST_IDLE;
          end else if (alm_on | c_stop) begin
            decel_cnt <= DECEL_STEPS[15:0];
            state <= ST_DECEL;
          end else if (index_edge) begin
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Pulse output formats
  // ---------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (!rstn) begin
      phase <= 2'h0;
      raw_pulse <= 1'b0;
      raw_sign <= 1'b0;
      pulse_out <= 1'b0;
      sign_out <= 1'b0;
    end else begin
      if (tick) begin
        phase <= dir_minus ? phase - 2'h1 : phase + 2'h1;
      end
      case (out_mode)
        `OUT_TWO_PULSE: begin
          raw_pulse <= moving & ~dir_minus & phase[0];
          raw_sign <= moving & dir_minus & phase[0];
        end
        `OUT_QUAD: begin
          // Gray sequence 00,01,11,10 forward; run backward for minus.
          raw_pulse <= phase[1];
          raw_sign <= phase[1] ^ phase[0];
        end
        default: begin
          raw_pulse <= moving & phase[0];
          raw_sign <= dir_minus;
        end
      endcase
      pulse_out <= raw_pulse ^ ctrl[`CTRL_PULSE_INV];
      sign_out <= raw_sign ^ ctrl[`CTRL_SIGN_INV];
    end
  end

  // ---------------------------------------------------------------
  // Encoder feedback
  // ---------------------------------------------------------------
  wire enc_step;
  wire enc_up;
  quad_decoder u_dec (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .phase_a(encoder_phase_a),
    .phase_b(encoder_phase_b),
    .mode(ctrl[`CTRL_ENC_MODE_HI:`CTRL_ENC_MODE_LO]),
    .reverse(ctrl[`CTRL_ENC_REV]),
    .step(enc_step),
    .up(enc_up)
  );

  // Clear wins over a step in the same cycle.
  always @(posedge clk_sys) begin
    if (!rstn) begin
      enc_count <= {COUNT_W{1'b0}};
    end else if (c_encclr) begin
      enc_count <= {COUNT_W{1'b0}};
    end else if (enc_step) begin
      enc_count <= enc_up ? enc_count + 1'b1 : enc_count - 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Interrupts
  // ---------------------------------------------------------------
  reg moving_q;
  always @* begin
    ev = {`IRQ_BITS{1'b0}};
    // The slowdown event marks the latch being taken, in either capture mode.
    ev[`IRQ_SD] = sd_on & dir_minus & moving & ~sd_latched;
    ev[`IRQ_HOME] = home_edge;
    ev[`IRQ_ALM] = alm_edge;
    ev[`IRQ_INDEX] = index_edge;
    ev[`IRQ_STOPPED] = moving_q & ~moving;
  end

  always @(posedge clk_sys) begin
    if (!rstn) begin
      irq_stat <= {`IRQ_BITS{1'b0}};
      moving_q <= 1'b0;
      irq <= 1'b0;
    end else begin
      moving_q <= moving;
      // Set wins over write-one-to-clear.
      if (wr_stat) begin
        irq_stat <= (irq_stat & ~pwdata[`IRQ_BITS-1:0]) | ev;
      end else begin
        irq_stat <= irq_stat | ev;
      end
      // Registered, so the pin follows the status one cycle late.
      irq <= |(irq_stat & irq_mask);
    end
  end
endmodule // axis_pulse_and_sensor_io

/* tb/axis_io_props.sv */
// Checker of APB timing, refusals and pin read-back of the axis I/O block.
module axis_io_props (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic minus_slowdown_input_n,
  input wire logic home_sensor_input_n,
  input wire logic alarm_input_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  chk_one_wait_state: assert property (psel && $rose(penable) |-> !pready ##1 pready)
    else $error("pready not after one wait state");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  chk_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  chk_ready_in_access: assert property (pready |-> psel && penable && $past(penable))
    else $error("pready outside access phase");
  chk_unmapped_refused: assert property (pready && paddr > 12'h018 |->
    pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access not refused");
  chk_mapped_ok: assert property (pready && paddr <= 12'h018 |-> !pslverr)
    else $error("mapped access refused");
  chk_cmd_reads_zero: assert property (pready && !pwrite && paddr == 12'h004 |-> prdata == 0)
    else $error("command register read not zero");
  chk_pins_read_back: assert property (pready && !pwrite && paddr == 12'h008 &&
    $stable(minus_slowdown_input_n) && $stable(home_sensor_input_n) &&
    $stable(alarm_input_n) |->
    prdata[2:0] == {alarm_input_n, home_sensor_input_n, minus_slowdown_input_n})
    else $error("raw pin states wrong in sub-status");
endmodule // axis_io_props

bind axis_pulse_and_sensor_io axis_io_props u_props (.clk_sys, .rstn, .psel, .penable,
  .pwrite, .paddr, .prdata, .pready, .pslverr, .minus_slowdown_input_n,
  .home_sensor_input_n, .alarm_input_n);

/* tb/motor_side_model.sv */
// Far-side model: driver step counters and a rotary encoder with index marker.
module motor_side_model (
  input wire logic clk_sys,
  input wire logic pulse_out,
  input wire logic sign_out,
  output logic enc_a,
  output logic enc_b,
  output logic idx_n
);
  timeunit 1ns;
  timeprecision 1ps;
  int np = 0;
  int ns = 0;
  logic pp = 0;
  logic ps = 0;
  logic sp = 0;
  initial begin
    enc_a = 0;
    enc_b = 0;
    idx_n = 1;
  end
  always @(posedge clk_sys) begin
    pp <= pulse_out;
    ps <= sign_out;
    if (pulse_out && !pp) begin
      np <= np + 1;
      sp <= sign_out;
    end
    if (sign_out && !ps) ns <= ns + 1;
  end
  // Gray steps; forward lets A lead B. The gap sets how slowly the shaft turns.
  task turn(input int n, input logic fwd, input int gap);
    for (int i = 0; i < 4 * n; i++) begin
      repeat (gap) @(posedge clk_sys);
      if (fwd ^ enc_a ^ enc_b) enc_a <= !enc_a;
      else enc_b <= !enc_b;
      idx_n <= !(i % 4 == 3);
    end
    repeat (gap) @(posedge clk_sys);
    idx_n <= 1;
  endtask
endmodule // motor_side_model

/* tb/tb_axis_pulse_and_sensor_io.sv */
// Self-checking bench of the axis I/O block with its far-side model.
module tb_axis_pulse_and_sensor_io;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 0;
  logic rstn = 0;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0;
  logic [31:0] prdata, rv;
  logic pready, pslverr, re, irq, pulse_out, sign_out, a, b, z;
  logic sd_n = 1;
  logic home_n = 1;
  logic alm_n = 1;
  int n_mismatch = 0;
  int compares = 0;
  int pc[2];
  int sc[2];
  logic sl[2];
  always #2.5 clk_sys = ~clk_sys;
  axis_pulse_and_sensor_io #(.DECEL_STEPS(2)) dut (.clk_sys, .rstn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .minus_slowdown_input_n(sd_n),
    .home_sensor_input_n(home_n), .alarm_input_n(alm_n), .encoder_phase_a(a),
    .encoder_phase_b(b), .encoder_index_marker_n(z), .pulse_out, .sign_out, .irq);
  motor_side_model m (.clk_sys, .pulse_out, .sign_out, .enc_a(a), .enc_b(b), .idx_n(z));
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  task apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rv = prdata;
    re = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge clk_sys);
  endtask
  task wait_c(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task t_regs;
    chk("outs", {irq, pulse_out, sign_out}, 0);
    apb(0, 12'h000, 0);
    chk("ctrl", rv, 0);
    apb(0, 12'h018, 0);
    chk("half", rv, 32'h64);
    apb(1, 12'h018, 32'h2);
    apb(0, 12'h004, 0);
    chk("cmd", rv, 0);
    apb(0, 12'h0fc, 0);
    chk("err", re, 1);
    $display("regs done");
  endtask
  task t_sense;
    apb(0, 12'h008, 0);
    chk("pins", rv, 32'h07);
    apb(1, 12'h000, 32'h2);
    wait_c(2);
    apb(0, 12'h008, 0);
    chk("sdpol", rv & 32'h3f, 32'h0f);
    apb(1, 12'h000, 0);
    apb(1, 12'h00c, 32'h1f);
    apb(1, 12'h010, 32'h4);
    alm_n <= 0;
    wait_c(3);
    apb(0, 12'h008, 0);
    chk("alm", rv & 32'h3f, 32'h23);
    chk("irq", irq, 1);
    alm_n <= 1;
    apb(1, 12'h00c, 32'h4);
    wait_c(2);
    chk("clr", irq, 0);
    apb(1, 12'h010, 32'h0);
    $display("sense done");
  endtask
  task run(input int cmd);
    int p0;
    apb(1, 12'h004, cmd);
    wait_c(60);
    apb(1, 12'h004, 32'h4);
    wait_c(40);
    p0 = m.np + m.ns;
    wait_c(30);
    chk("stop", m.np + m.ns, p0);
  endtask
  task t_alarm;
    apb(1, 12'h004, 32'h1);
    wait_c(10);
    alm_n <= 0;
    wait_c(3);
    apb(0, 12'h008, 0);
    chk("alm_halt", rv & 32'h300, 32'h0);
    alm_n <= 1;
    apb(1, 12'h000, 32'h10);
    apb(1, 12'h004, 32'h1);
    wait_c(10);
    alm_n <= 0;
    wait_c(1);
    apb(0, 12'h008, 0);
    chk("alm_decel", rv & 32'h300, 32'h200);
    wait_c(20);
    apb(0, 12'h008, 0);
    chk("alm_done", rv & 32'h300, 32'h0);
    alm_n <= 1;
    apb(1, 12'h000, 0);
    $display("alarm done");
  endtask
  task t_pulse;
    for (int md = 0; md < 3; md++) begin
      apb(1, 12'h000, md << 5);
      for (int d = 0; d < 2; d++) begin
        pc[d] = m.np;
        sc[d] = m.ns;
        run(1 << d);
        pc[d] = m.np - pc[d];
        sc[d] = m.ns - sc[d];
        sl[d] = m.sp;
      end
      chk("p+", pc[0] > 0, 1);
      chk("p-", pc[1] > 0, md != 1);
      chk("s+", sc[0] > 0, md == 2);
      chk("s-", sc[1] > 1, md != 0);
      if (md != 1) chk("dir", sl[0] != sl[1], 1);
    end
    apb(1, 12'h000, 32'h180);
    wait_c(4);
    chk("inv", pulse_out, 1);
    chk("inv_sign", sign_out, 0);
    apb(1, 12'h000, 0);
    $display("pulse done");
  endtask
  task t_enc;
    int ev[4] = '{2, 4, 8, 0};
    for (int md = 0; md < 4; md++)
      for (int r = 0; r < 3; r++) begin
        apb(1, 12'h000, md << 9 | (r == 1) << 11);
        apb(1, 12'h004, 32'h20);
        m.turn(2, r != 2, 2);
        wait_c(4);
        apb(0, 12'h014, 0);
        chk("enc", rv, r ? -ev[md] : ev[md]);
      end
    $display("encoder done");
  endtask
  task t_home;
    apb(1, 12'h00c, 32'h1f);
    apb(1, 12'h000, 32'h1000);
    apb(1, 12'h004, 32'h8);
    wait_c(10);
    home_n <= 0;
    wait_c(10);
    apb(0, 12'h008, 0);
    chk("wait", rv & 32'h300, 32'h300);
    m.turn(1, 0, 2);
    wait_c(20);
    apb(0, 12'h00c, 0);
    chk("home", rv & 32'h1a, 32'h1a);
    home_n <= 1;
    $display("home done");
  endtask
  task t_sd;
    apb(1, 12'h000, 32'h1);
    apb(1, 12'h004, 32'h2);
    wait_c(10);
    sd_n <= 0;
    wait_c(2);
    sd_n <= 1;
    wait_c(40);
    apb(0, 12'h008, 0);
    chk("latch", rv & 32'h340, 32'h40);
    apb(0, 12'h00c, 0);
    chk("sd_event", rv & 32'h1, 32'h1);
    apb(1, 12'h004, 32'h10);
    apb(0, 12'h008, 0);
    chk("unlatch", rv & 32'h40, 0);
    $display("slowdown done");
  endtask
  task final_report;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #100000;
    n_mismatch++;
    final_report;
  end
  initial begin
    wait_c(8);
    rstn <= 1;
    wait_c(1);
    t_regs;
    t_sense;
    t_alarm;
    t_pulse;
    t_enc;
    t_home;
    t_sd;
    final_report;
  end
endmodule // tb_axis_pulse_and_sensor_io
